// ---- pkg/eeprom_ctl_pkg.sv ----
// Constants, field positions and state codes for the data EEPROM write controller.
package eeprom_ctl_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CTL_ADDR = 8'hEA;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam int unsigned STANDBY_BIT = 6;
    localparam int unsigned START_BIT = 3;
    localparam int unsigned PAR_MODE_BIT = 2;
    localparam int unsigned BUSY_BIT = 1;
    localparam int unsigned ENABLE_BIT = 0;

    // ************************************************************
    // Array geometry
    // ************************************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ROW_BYTES = 8;
    localparam int unsigned MEM_ADDR_W = 7;
    localparam logic [1:0] REGION_TOP = 2'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned PROG_TIME_NS = 5000;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_COMMIT = 2'b10
    } prog_state_t;

endpackage : eeprom_ctl_pkg

// ---- logic/eeprom_cell_array.sv ----
// Nonvolatile cell array model with one write port and a registered read port.
`timescale 1ns/1ps
module eeprom_cell_array #(
    parameter int unsigned DATA_W = 8,
    parameter int unsigned ADDR_W = 7
) (
    input wire logic clk_in,                 // Core clock.
    input wire logic we_in,                  // Write one byte.
    input wire logic [ADDR_W-1:0] waddr_in,  // Write address.
    input wire logic [DATA_W-1:0] wdata_in,  // Write data.
    input wire logic re_in,                  // Read one byte.
    input wire logic [ADDR_W-1:0] raddr_in,  // Read address.
    output logic [DATA_W-1:0] rdata_out      // Registered read data.
);

    // Cells are not cleared by reset, as nonvolatile storage would not be.
    logic [DATA_W-1:0] cells [2**ADDR_W];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            cells[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (re_in) begin
            rdata_out <= cells[raddr_in];
        end
    end

endmodule : eeprom_cell_array

// ---- logic/eeprom_write_control.sv ----
// Data EEPROM control register, row latches and programming sequencer.
//
// Summary of operation
// - Standby bit 6 disables the array; accesses are meaningless, power is minimal.
// - Setting start bit 3 in parallel mode programs the 8-byte row together.
// - Hardware clears the start bit when programming finishes.
// - Row bytes not written since parallel mode entry keep their contents.
// - In parallel mode without start, up to 8 row bytes are latched.
// - The page select and address bits A5..A3 fix the row; A2..A0 pick the byte.
// - Hardware clears parallel mode enable at the end of parallel programming.
// - Clearing parallel mode before start discards latched data, array unchanged.
// - Busy bit 1 is set throughout a programming cycle, cleared after.
// - Array access while busy is aborted; running programming completes.
// - Program enable bit 0 gates programming; set it before writing.
// - A write with program enable clear starts no programming cycle.
// - STOP disables the array immediately to save power.
// - Start is accepted only when enable and parallel mode are already set.
// - Setting parallel mode clears all 8 row latches; row held from the first latched write.
// - While busy, control writes are ignored; only busy reads back.
`timescale 1ns/1ps
module eeprom_write_control #(
    parameter int unsigned PROG_CYCLES = eeprom_ctl_pkg::PROG_CYCLES
) (
    input wire logic CORE_CLK_IN,         // Core clock, 50 MHz.
    input wire logic RST_N_IN,            // Synchronous reset, active low.
    input wire logic [7:0] ADDR_IN,       // Data-space address.
    input wire logic WR_STB_IN,           // One-cycle write strobe.
    input wire logic RD_STB_IN,           // One-cycle read strobe.
    input wire logic [7:0] WR_DATA_IN,    // Write data.
    input wire logic EE_SEL_IN,           // An EEPROM page is mapped at 00h-3Fh.
    input wire logic PAGE_IN,             // Selected EEPROM page.
    input wire logic STOP_IN,             // Core is in STOP mode.
    output logic [7:0] RD_DATA_OUT,       // Read data, two cycles after strobe.
    output logic RD_VALID_OUT,            // Read data valid pulse.
    output logic BUSY_OUT,                // Programming cycle in progress.
    output logic EE_POWER_DOWN_OUT,       // Array powered down.
    output logic ABORT_OUT                // Access refused pulse.
);

    localparam int unsigned RB = eeprom_ctl_pkg::ROW_BYTES;
    localparam int unsigned CW = eeprom_ctl_pkg::CNT_W;
    localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

    // ************************************************************
    // State
    // ************************************************************
    eeprom_ctl_pkg::prog_state_t state;
    eeprom_ctl_pkg::prog_state_t next_state;
    logic eeprom_standby;
    logic program_enable;
    logic parallel_mode_enable;
    logic parallel_start;
    logic [CW-1:0] cnt;
    logic [2:0] slot;
    logic [RB-1:0] mask;
    logic [7:0] row_data [RB];
    logic row_held;
    logic [3:0] row_addr;
    logic p1_ee;
    logic p1_ctl;
    logic p1_null;
    logic [7:0] p1_ctl_val;
    logic [7:0] mem_rdata;

    // ************************************************************
    // Decode
    // ************************************************************
    wire busy = state != eeprom_ctl_pkg::ST_IDLE;
    wire ctl_hit = ADDR_IN == eeprom_ctl_pkg::CTL_ADDR;
    wire ee_hit = EE_SEL_IN && (ADDR_IN[7:6] == eeprom_ctl_pkg::REGION_TOP);
    wire ee_disabled = eeprom_standby || STOP_IN;
    wire ee_blocked = busy || ee_disabled;
    wire ctl_wr = WR_STB_IN && ctl_hit && !busy;
    wire ee_wr_req = WR_STB_IN && ee_hit;
    wire ee_rd_req = RD_STB_IN && ee_hit;
    wire [3:0] row_of_req = {PAGE_IN, ADDR_IN[5:3]};
    wire [2:0] idx = ADDR_IN[2:0];
    wire row_match = !row_held || (row_of_req == row_addr);
    wire par_load = ee_wr_req && !ee_blocked && parallel_mode_enable
        && !parallel_start && row_match;
    wire byte_go = ee_wr_req && !ee_blocked && !parallel_mode_enable && program_enable;
    wire load = par_load || byte_go;
    wire start_go = ctl_wr && WR_DATA_IN[eeprom_ctl_pkg::START_BIT]
        && program_enable && parallel_mode_enable;
    wire par_rise = ctl_wr && WR_DATA_IN[eeprom_ctl_pkg::PAR_MODE_BIT] && !parallel_mode_enable;
    wire par_cancel = ctl_wr && !WR_DATA_IN[eeprom_ctl_pkg::PAR_MODE_BIT] && parallel_mode_enable;
    wire commit_done = (state == eeprom_ctl_pkg::ST_COMMIT) && (slot == 3'h7);
    wire clear_mask = par_rise || par_cancel || commit_done;
    wire rd_ok = ee_rd_req && !ee_blocked;
    // A write outside the latched row would corrupt the held row, so it is refused.
    wire abort_evt = ((ee_wr_req || ee_rd_req) && ee_blocked)
        || (ee_wr_req && !ee_blocked && parallel_mode_enable && !row_match);
    wire next_standby = ctl_wr ? WR_DATA_IN[eeprom_ctl_pkg::STANDBY_BIT] : eeprom_standby;
    wire mem_we = (state == eeprom_ctl_pkg::ST_COMMIT) && mask[slot];
    wire [6:0] mem_waddr = {row_addr, slot};
    wire [6:0] mem_raddr = {PAGE_IN, ADDR_IN[5:0]};
    wire [7:0] ctl_read_val = {6'h00, busy, 1'h0};
    wire [7:0] next_rd_data = p1_ee ? mem_rdata : (p1_ctl ? p1_ctl_val : 8'h00);

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            eeprom_standby <= 1'b0;
            program_enable <= 1'b0;
        end else if (ctl_wr) begin
            eeprom_standby <= WR_DATA_IN[eeprom_ctl_pkg::STANDBY_BIT];
            program_enable <= WR_DATA_IN[eeprom_ctl_pkg::ENABLE_BIT];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            parallel_mode_enable <= 1'b0;
            parallel_start <= 1'b0;
        end else if (commit_done) begin
            parallel_mode_enable <= 1'b0;
            parallel_start <= 1'b0;
        end else if (ctl_wr) begin
            parallel_mode_enable <= WR_DATA_IN[eeprom_ctl_pkg::PAR_MODE_BIT];
            parallel_start <= start_go;
        end
    end

    // ************************************************************
    // Row latches
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < RB; gi++) begin : g_row
            always_ff @(posedge CORE_CLK_IN) begin
                if (!RST_N_IN) begin
                    row_data[gi] <= 8'h00;
                    mask[gi] <= 1'b0;
                end else if (clear_mask) begin
                    mask[gi] <= 1'b0;
                end else if (load && (idx == 3'(gi))) begin
                    row_data[gi] <= WR_DATA_IN;
                    mask[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            row_held <= 1'b0;
            row_addr <= 4'h0;
        end else if (clear_mask) begin
            row_held <= 1'b0;
        end else if (load) begin
            row_held <= 1'b1;
            row_addr <= row_of_req;
        end
    end

    // ************************************************************
    // Programming sequencer
    // ************************************************************
    // The cells are written only after the full programming time, one byte
    // per clock, so a cancelled or refused row never touches the array.
    always_comb begin
        next_state = state;
        unique case (state)
            eeprom_ctl_pkg::ST_IDLE: begin
                if (start_go || byte_go) begin
                    next_state = eeprom_ctl_pkg::ST_PROG;
                end
            end
            eeprom_ctl_pkg::ST_PROG: begin
                if (cnt == '0) begin
                    next_state = eeprom_ctl_pkg::ST_COMMIT;
                end
            end
            eeprom_ctl_pkg::ST_COMMIT: begin
                if (slot == 3'h7) begin
                    next_state = eeprom_ctl_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = eeprom_ctl_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            state <= eeprom_ctl_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            cnt <= '0;
        end else if (state == eeprom_ctl_pkg::ST_IDLE) begin
            cnt <= PROG_LAST;
        end else if (state == eeprom_ctl_pkg::ST_PROG) begin
            cnt <= cnt - CW'(1);
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            slot <= 3'h0;
        end else if (state == eeprom_ctl_pkg::ST_COMMIT) begin
            slot <= slot + 3'h1;
        end else begin
            slot <= 3'h0;
        end
    end

    eeprom_cell_array #(
        .DATA_W(eeprom_ctl_pkg::DATA_W),
        .ADDR_W(eeprom_ctl_pkg::MEM_ADDR_W)
    ) u_cells (
        .clk_in(CORE_CLK_IN),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(row_data[slot]),
        .re_in(rd_ok),
        .raddr_in(mem_raddr),
        .rdata_out(mem_rdata)
    );

    // ************************************************************
    // Read pipeline and outputs
    // ************************************************************
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            p1_ee <= 1'b0;
            p1_ctl <= 1'b0;
            p1_null <= 1'b0;
            p1_ctl_val <= eeprom_ctl_pkg::CTL_RESET;
        end else begin
            p1_ee <= rd_ok;
            p1_ctl <= RD_STB_IN && ctl_hit;
            p1_null <= ee_rd_req && ee_blocked;
            p1_ctl_val <= ctl_read_val;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            RD_DATA_OUT <= 8'h00;
            RD_VALID_OUT <= 1'b0;
            BUSY_OUT <= 1'b0;
            EE_POWER_DOWN_OUT <= 1'b0;
            ABORT_OUT <= 1'b0;
        end else begin
            RD_DATA_OUT <= next_rd_data;
            RD_VALID_OUT <= p1_ee || p1_ctl || p1_null;
            BUSY_OUT <= next_state != eeprom_ctl_pkg::ST_IDLE;
            EE_POWER_DOWN_OUT <= next_standby || STOP_IN;
            ABORT_OUT <= abort_evt;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    logic [CW-1:0] prog_len;
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN || state != eeprom_ctl_pkg::ST_PROG) begin
            prog_len <= '0;
        end else begin
            prog_len <= prog_len + CW'(1);
        end
    end

    sequence commit_sweep;
        (state == eeprom_ctl_pkg::ST_COMMIT)[*8] ##1 (state == eeprom_ctl_pkg::ST_IDLE);
    endsequence

    sequence blocked_read;
        ee_rd_req && ee_disabled && !busy;
    endsequence

    chk_start_gated: assert property ($rose(parallel_start)
        |-> $past(program_enable) && $past(parallel_mode_enable))
        else $error("Start bit set without enable and parallel mode.");
    chk_start_busy: assert property (start_go |=> BUSY_OUT && parallel_start)
        else $error("Parallel start did not begin a cycle.");
    chk_prog_length: assert property ($fell(state == eeprom_ctl_pkg::ST_PROG)
        |-> prog_len == CW'(PROG_CYCLES))
        else $error("Programming time differs from the configured count.");
    chk_commit_sweep: assert property ($rose(state == eeprom_ctl_pkg::ST_COMMIT)
        |-> commit_sweep)
        else $error("Row commit did not cover eight slots.");
    chk_end_clears: assert property (commit_done
        |=> !parallel_start && !parallel_mode_enable && !BUSY_OUT)
        else $error("Start or parallel mode survived the end of programming.");
    chk_unwritten_kept: assert property (mem_we |-> mask[slot] && BUSY_OUT)
        else $error("Unlatched row byte written.");
    // A latch flag may only move on a latching write or a clear, never by itself.
    chk_mask_source: assert property (!$stable(mask) |-> $past(load) || $past(clear_mask))
        else $error("Row latch flags changed without a write or a clear.");
    chk_cancel_drops: assert property (par_rise || par_cancel
        |=> mask == '0 && !row_held)
        else $error("Row latches not cleared on mode change.");
    chk_ctl_frozen: assert property (busy && WR_STB_IN && ctl_hit
        |=> $stable(program_enable) && $stable(eeprom_standby))
        else $error("Control register changed while busy.");
    chk_no_enable: assert property (ee_wr_req && !program_enable
        && !parallel_mode_enable && !busy |=> !BUSY_OUT)
        else $error("Write without program enable started a cycle.");
    chk_byte_cycle: assert property (byte_go
        |=> BUSY_OUT ##1 (state == eeprom_ctl_pkg::ST_PROG))
        else $error("Byte write did not start a cycle.");
    // An access in the last commit cycle is still refused although busy then drops.
    chk_busy_abort: assert property ((ee_wr_req || ee_rd_req) && busy
        |=> ABORT_OUT && (BUSY_OUT || $past(commit_done)))
        else $error("Access during busy not aborted.");
    chk_row_fixed: assert property (ee_wr_req && !ee_blocked && parallel_mode_enable
        && !row_match |=> ABORT_OUT && $stable(mask))
        else $error("Write outside the held row was not refused.");
    chk_standby_read: assert property (blocked_read
        |-> ##2 RD_VALID_OUT && RD_DATA_OUT == 8'h00)
        else $error("Disabled array returned data.");
    chk_stop_off: assert property (STOP_IN |=> EE_POWER_DOWN_OUT)
        else $error("STOP did not power the array down.");

endmodule : eeprom_write_control

// ---- sim/cpu_bus_model.sv ----
// Core-side model that issues control register and array accesses.
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic clk_in,            // Core clock.
    input wire logic rd_valid_in,       // Read answer pulse.
    input wire logic [7:0] rd_data_in,  // Read answer data.
    output logic [7:0] addr_out,        // Data-space address.
    output logic [7:0] wr_data_out,     // Write data.
    output logic wr_stb_out,            // Write strobe.
    output logic rd_stb_out             // Read strobe.
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    initial begin
        addr_out = 8'h00;
        wr_data_out = 8'h00;
        wr_stb_out = 1'b0;
        rd_stb_out = 1'b0;
    end

    // Released buses show the inverse of their last value, so sampling outside the strobe
    // cycle picks up garbage instead of a lucky match.
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        addr_out = a;
        wr_data_out = (a == eeprom_ctl_pkg::CTL_ADDR) ? (d & 8'hCF) : d;
        wr_stb_out = 1'b1;
        @(posedge clk_in);
        #2;
        wr_stb_out = 1'b0;
        addr_out = ~addr_out;
        wr_data_out = ~wr_data_out;
        @(posedge clk_in);
        #2;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        d = 8'h00;
        ok = 1'b0;
        addr_out = a;
        rd_stb_out = 1'b1;
        @(posedge clk_in);
        #2;
        rd_stb_out = 1'b0;
        addr_out = ~addr_out;
        repeat (4) begin
            if (!ok && rd_valid_in === 1'b1) begin
                d = rd_data_in;
                ok = 1'b1;
            end
            @(posedge clk_in);
            #2;
        end
    endtask : bus_read

    task automatic wait_idle();
        logic [7:0] s;
        logic ok;
        repeat (40) begin
            bus_read(eeprom_ctl_pkg::CTL_ADDR, s, ok);
            if (ok && s[eeprom_ctl_pkg::BUSY_BIT] == 1'b0) return;
        end
    endtask : wait_idle

    task automatic enter_parallel();
        bus_write(eeprom_ctl_pkg::CTL_ADDR, 8'h05);
    endtask : enter_parallel
endmodule : cpu_bus_model

// ---- sim/test_eeprom_write_control.sv ----
// Self-checking testbench for the data EEPROM write controller.
`timescale 1ns/1ps
module test_eeprom_write_control;
    localparam int PROG = 8;
    localparam logic [7:0] CTL = eeprom_ctl_pkg::CTL_ADDR;
    logic core_clk, rst_n, wr_stb, rd_stb, ee_sel, page, stop, ok;
    logic rd_valid, busy, power_down, abort;
    logic [7:0] addr, wr_data, rd_data, d;
    int n_fail = 0;
    int samples_checked = 0;
    int n_abort = 0;
    int busy_run = 0;
    int last_run = 0;
    int cycles = 0;

    eeprom_write_control #(.PROG_CYCLES(PROG)) eeprom_write_control_inst (
        .CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_STB_IN(wr_stb),
        .RD_STB_IN(rd_stb), .WR_DATA_IN(wr_data), .EE_SEL_IN(ee_sel), .PAGE_IN(page),
        .STOP_IN(stop), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid), .BUSY_OUT(busy),
        .EE_POWER_DOWN_OUT(power_down), .ABORT_OUT(abort));
    cpu_bus_model cpu_bus_model_inst (.clk_in(core_clk), .rd_valid_in(rd_valid),
        .rd_data_in(rd_data), .addr_out(addr), .wr_data_out(wr_data), .wr_stb_out(wr_stb),
        .rd_stb_out(rd_stb));

    // ************************************************************
    // Monitors and helpers
    // ************************************************************
    // Counting at the edge sees the pre-update values, so a run length is exact in cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (abort === 1'b1) n_abort++;
        if (busy === 1'b1) busy_run++;
        else if (busy_run != 0) begin
            last_run = busy_run;
            busy_run = 0;
        end
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic expect_rd(input logic [7:0] a, input logic [7:0] exp);
        cpu_bus_model_inst.bus_read(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask : expect_rd

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #2;
    endtask : settle

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        expect_rd(CTL, 8'h00);
        check({6'h00, power_down, busy}, 8'h00);
        cpu_bus_model_inst.bus_read(8'hC0, d, ok);
        check({7'h00, ok}, 8'h00);
        ee_sel = 1'b0;
        cpu_bus_model_inst.bus_read(8'h05, d, ok);
        check({7'h00, ok}, 8'h00);
        ee_sel = 1'b1;
    endtask : t_reset

    // Byte write, an access and a control write landing mid-cycle, then enable cleared.
    task automatic t_byte();
        int a;
        cpu_bus_model_inst.bus_write(CTL, 8'h01);
        cpu_bus_model_inst.bus_write(8'h05, 8'hA5);
        check({7'h00, busy}, 8'h01);
        a = n_abort;
        cpu_bus_model_inst.bus_read(8'h05, d, ok);
        check(d, 8'h00);
        check(8'(n_abort - a), 8'h01);
        cpu_bus_model_inst.bus_write(CTL, 8'h40);
        expect_rd(CTL, 8'h02);
        cpu_bus_model_inst.wait_idle();
        check(8'(last_run), 8'(PROG + 8));
        check({7'h00, power_down}, 8'h00);
        expect_rd(8'h05, 8'hA5);
        cpu_bus_model_inst.bus_write(8'h06, 8'h3C);
        cpu_bus_model_inst.wait_idle();
        cpu_bus_model_inst.bus_write(CTL, 8'h00);
        cpu_bus_model_inst.bus_write(8'h06, 8'hC3);
        settle();
        check({7'h00, busy}, 8'h00);
        expect_rd(8'h06, 8'h3C);
    endtask : t_byte

    task automatic t_parallel();
        int a;
        cpu_bus_model_inst.bus_write(CTL, 8'h0D);
        check({7'h00, busy}, 8'h00);
        cpu_bus_model_inst.bus_write(8'h01, 8'h5A);
        cpu_bus_model_inst.bus_write(8'h02, 8'h6B);
        a = n_abort;
        cpu_bus_model_inst.bus_write(8'h10, 8'h77);
        check(8'(n_abort - a), 8'h01);
        check({7'h00, busy}, 8'h00);
        cpu_bus_model_inst.bus_write(CTL, 8'h0D);
        check({7'h00, busy}, 8'h01);
        cpu_bus_model_inst.wait_idle();
        check(8'(last_run), 8'(PROG + 8));
        cpu_bus_model_inst.bus_write(8'h03, 8'h99);
        check({7'h00, busy}, 8'h01);
        cpu_bus_model_inst.wait_idle();
        expect_rd(8'h01, 8'h5A);
        expect_rd(8'h02, 8'h6B);
        expect_rd(8'h05, 8'hA5);
        expect_rd(8'h06, 8'h3C);
        expect_rd(8'h03, 8'h99);
        cpu_bus_model_inst.enter_parallel();
        cpu_bus_model_inst.bus_write(8'h01, 8'hEE);
        cpu_bus_model_inst.bus_write(CTL, 8'h01);
        settle();
        check({7'h00, busy}, 8'h00);
        cpu_bus_model_inst.enter_parallel();
        cpu_bus_model_inst.bus_write(8'h02, 8'h44);
        cpu_bus_model_inst.bus_write(CTL, 8'h0D);
        cpu_bus_model_inst.wait_idle();
        expect_rd(8'h01, 8'h5A);
        expect_rd(8'h02, 8'h44);
    endtask : t_parallel

    task automatic t_standby();
        int a;
        cpu_bus_model_inst.bus_write(CTL, 8'h40);
        settle();
        check({7'h00, power_down}, 8'h01);
        a = n_abort;
        cpu_bus_model_inst.bus_read(8'h05, d, ok);
        check(d, 8'h00);
        check(8'(n_abort - a), 8'h01);
        cpu_bus_model_inst.bus_write(CTL, 8'h00);
        stop = 1'b1;
        settle();
        check({7'h00, power_down}, 8'h01);
        cpu_bus_model_inst.bus_write(8'h05, 8'h00);
        check(8'(n_abort - a), 8'h02);
        stop = 1'b0;
        settle();
        check({7'h00, power_down}, 8'h00);
        expect_rd(8'h05, 8'hA5);
    endtask : t_standby

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        rst_n = 1'b0;
        ee_sel = 1'b1;
        page = 1'b0;
        stop = 1'b0;
        repeat (2) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        t_reset();
        t_byte();
        t_parallel();
        t_standby();
        conclude();
    end
endmodule : test_eeprom_write_control
